// [sppr_pkg.sv]
/*
  Package for the shared pin port with input remap: register offsets,
  field positions, reset values and port width.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package sppr_pkg;
  localparam int unsigned NPINS          = 16;
  localparam int unsigned NREMAP         = 26;
  localparam int unsigned SEL_W          = 5;
  localparam logic [11:0] OFF_DIR        = 12'h000;
  localparam logic [11:0] OFF_LAT        = 12'h004;
  localparam logic [11:0] OFF_PIN        = 12'h008;
  localparam logic [11:0] OFF_SEL        = 12'h00c;
  localparam logic [11:0] OFF_PERI_EN    = 12'h010;
  localparam int unsigned SCK_LSB        = 8;
  localparam int unsigned SDI_LSB        = 0;
  localparam logic [4:0]  SEL_GND        = 5'h1f;
  localparam logic [4:0]  SEL_MAX        = 5'h19;
  localparam logic [15:0] DIR_RST        = 16'hffff;
  localparam logic [15:0] LAT_RST        = 16'h0000;
  localparam logic [15:0] SEL_RST        = 16'h1f1f;
  localparam logic [15:0] SEL_MASK       = 16'h1f1f;
  localparam logic [15:0] PERI_EN_RST    = 16'h0000;
endpackage

// [sppr_pin_mux.sv]
/*
  One shared pin's output multiplexer pair and loop-through block.
  Assumes the peripheral signals are synchronous to the port clock.
*/
`timescale 1ns/1ns
module sppr_pin_mux (
  // Port side
  input  wire logic port_dir,
  input  wire logic port_lat,
  input  wire logic bit_valid,
  // Peripheral side
  input  wire logic peri_en,
  input  wire logic peri_drive,
  input  wire logic peri_out,
  // Pin side
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe_n,
  output logic      peri_in
);
  logic peri_owns;
  logic port_drives;

  // Peripheral wins only while enabled and actively driving
  assign peri_owns   = bit_valid & peri_en & peri_drive;
  assign port_drives = bit_valid & ~port_dir & ~peri_owns;
  // Absent bits stay low on pin_out and peri_in with the driver off, so a stale latch bit never leaks out
  assign pin_out     = bit_valid & (peri_owns ? peri_out : port_lat);
  assign pin_oe_n    = ~(peri_owns | port_drives);
  // Peripheral never sees the port's own drive, only a real pin level
  assign peri_in     = bit_valid & ~port_drives & pin_in;
endmodule

// [sppr_remap_sel.sv]
/*
  Remappable input selector: code picks one of the remap pins or ground.
  Assumes remap pins are already sampled levels.
*/
`timescale 1ns/1ns
module sppr_remap_sel
  import sppr_pkg::*;
(
  // Selection
  input  wire logic [SEL_W-1:0]  code,
  input  wire logic [NREMAP-1:0] rp_in,
  // Result
  output logic                   sel_out
);
  // Ground and reserved codes both give zero; reserved is not driven
  assign sel_out = (code <= SEL_MAX) ? rp_in[code] : 1'b0;
endmodule

// [sppr_port.sv]
/*
  Shared pin parallel port with serial input remap, APB register slave.
  Assumes peripheral drive requests come from their modules
  synchronously to pclk; enables are the peripheral-enable register; board pin levels are already synchronous.
*/
// Added by the designer: the address map and the APB slave port.
// Contract
// - Each shared pin has output data and enable muxes, peripheral first.
// - Port output never loops into a shared peripheral input.
// - An enabled, driving peripheral switches off the port driver; pin reads still work.
// - An enabled but idle peripheral lets the port drive the pin.
// - Direction one means input with driver off, zero means output.
// - Any reset makes every pin an input.
// - Latch reads return the latch; latch writes update it.
// - Pin-level reads return sampled pins; writes there update the latch.
// - Unimplemented bits are disabled and read zero in the direction, latch and pin-level registers; peripheral-enable reads return them as written.
// - Pins shared only with input functions act as dedicated port pins.
`timescale 1ns/1ns
module sppr_port
  import sppr_pkg::*;
#(
  parameter logic [NPINS-1:0] VALID_MASK = 16'hffff
)(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Peripherals sharing the pins
  input  wire logic [NPINS-1:0]  peri_drive,
  input  wire logic [NPINS-1:0]  peri_out,
  output logic      [NPINS-1:0]  peri_in,
  // Board pins
  input  wire logic [NPINS-1:0]  pin_in,
  output logic      [NPINS-1:0]  pin_out,
  output logic      [NPINS-1:0]  pin_oe_n,
  // Remap pins and selected serial inputs
  input  wire logic [NREMAP-1:0] remappable_pin_n,
  output logic                   serial_clock_input,
  output logic                   serial_data_input
);
  logic [15:0] pin_direction_register_r;
  logic [15:0] output_latch_register_r;
  logic [15:0] pin_level_register_r;
  logic [15:0] serial_input_pin_select_r;
  logic [15:0] peri_en_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [NPINS-1:0] pin_out_r;
  logic [NPINS-1:0] pin_oe_n_r;
  logic [NPINS-1:0] peri_in_r;
  logic        sck_r;
  logic        sdi_r;
  logic [NPINS-1:0] pin_out_nxt;
  logic [NPINS-1:0] pin_oe_n_nxt;
  logic [NPINS-1:0] peri_in_nxt;
  logic        sck_nxt;
  logic        sdi_nxt;

  // Address decode
  logic setup;
  logic wr;
  logic hit_dir;
  logic hit_lat;
  logic hit_pin;
  logic hit_sel;
  logic hit_pen;
  logic hit_any;
  logic [31:0] rd_nxt;
  assign setup   = psel & ~penable;
  // Write lands only at the edge where the master sees pready high
  assign wr      = psel & penable & pwrite & pready_r;
  assign hit_dir = (paddr == OFF_DIR);
  assign hit_lat = (paddr == OFF_LAT);
  assign hit_pin = (paddr == OFF_PIN);
  assign hit_sel = (paddr == OFF_SEL);
  assign hit_pen = (paddr == OFF_PERI_EN);
  assign hit_any = hit_dir | hit_lat | hit_pin | hit_sel | hit_pen;

  // Read mux; unimplemented bits masked to zero for direction, latch and pin levels
  assign rd_nxt =
    hit_dir ? {16'h0000, pin_direction_register_r & VALID_MASK} :
    hit_lat ? {16'h0000, output_latch_register_r & VALID_MASK} :
    hit_pin ? {16'h0000, pin_level_register_r & VALID_MASK} :
    hit_sel ? {16'h0000, serial_input_pin_select_r} :
    hit_pen ? {16'h0000, peri_en_r} :
              32'h0000_0000;

  // APB answer one cycle after setup, in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup & ~hit_any;
      prdata_r  <= (setup & ~pwrite) ? rd_nxt : 32'h0000_0000;
    end
  end

  // Register writes take effect at the access edge; reset forces inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction_register_r  <= DIR_RST;
      output_latch_register_r   <= LAT_RST;
      serial_input_pin_select_r <= SEL_RST;
      peri_en_r                 <= PERI_EN_RST;
    end else if (wr) begin
      if (hit_dir) begin
        pin_direction_register_r <= pwdata[15:0];
      end
      if (hit_lat | hit_pin) begin
        output_latch_register_r <= pwdata[15:0];
      end
      if (hit_sel) begin
        serial_input_pin_select_r <= pwdata[15:0] & SEL_MASK;
      end
      if (hit_pen) begin
        peri_en_r <= pwdata[15:0];
      end
    end
  end

  // Pin level sampling, one cycle of capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level_register_r <= 16'h0000;
    end else begin
      pin_level_register_r <= pin_in & VALID_MASK;
    end
  end

  // One mux pair per shared pin
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      sppr_pin_mux u_mux (
        .port_dir   (pin_direction_register_r[g]),
        .port_lat   (output_latch_register_r[g]),
        .bit_valid  (VALID_MASK[g]),
        .peri_en    (peri_en_r[g]),
        .peri_drive (peri_drive[g]),
        .peri_out   (peri_out[g]),
        .pin_in     (pin_in[g]),
        .pin_out    (pin_out_nxt[g]),
        .pin_oe_n   (pin_oe_n_nxt[g]),
        .peri_in    (peri_in_nxt[g])
      );
    end
  endgenerate

  // Remap selectors for the serial inputs
  sppr_remap_sel u_sck (
    .code    (serial_input_pin_select_r[SCK_LSB +: SEL_W]),
    .rp_in   (remappable_pin_n),
    .sel_out (sck_nxt)
  );
  sppr_remap_sel u_sdi (
    .code    (serial_input_pin_select_r[SDI_LSB +: SEL_W]),
    .rp_in   (remappable_pin_n),
    .sel_out (sdi_nxt)
  );

  // Outputs registered; costs one cycle of latency on every path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_r  <= {NPINS{1'b0}};
      pin_oe_n_r <= {NPINS{1'b1}};
      peri_in_r  <= {NPINS{1'b0}};
      sck_r      <= 1'b0;
      sdi_r      <= 1'b0;
    end else begin
      pin_out_r  <= pin_out_nxt;
      pin_oe_n_r <= pin_oe_n_nxt;
      peri_in_r  <= peri_in_nxt;
      sck_r      <= sck_nxt;
      sdi_r      <= sdi_nxt;
    end
  end

  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
  assign pin_out            = pin_out_r;
  assign pin_oe_n           = pin_oe_n_r;
  assign peri_in            = peri_in_r;
  assign serial_clock_input = sck_r;
  assign serial_data_input  = sdi_r;
endmodule

// [sppr_port_sva.sv]
/* Checker for sppr_port: APB answer timing, pin safety, remap ground.
   Bound from the bench; sees only the port's APB signals, pin enables, remap pins and selected serial inputs. */
`timescale 1ns/1ns
module sppr_port_sva
  import sppr_pkg::*;
#(parameter logic [NPINS-1:0] VALID_MASK = 16'hffff)(
  // Clock, reset, APB
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Pins and remap
  input wire logic [NPINS-1:0]  pin_oe_n,
  input wire logic [NREMAP-1:0] remappable_pin_n,
  input wire logic              serial_clock_input,
  input wire logic              serial_data_input
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  chk_err_read: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error answer");
  chk_idle_rdata: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  chk_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  chk_unimpl_off: assert property ((pin_oe_n | VALID_MASK) == 16'hffff)
    else $error("absent pin driven");
  chk_remap_low: assert property ($past(remappable_pin_n) == 26'h0 |->
    !serial_clock_input && !serial_data_input)
    else $error("serial input high from low pins");
  // Main scenarios
  cover property (pready && pslverr);
  cover property (pin_oe_n != 16'hffff);
  cover property (serial_clock_input && serial_data_input);
endmodule

// [sppr_board_model.sv]
/* Board pins: a driven pin follows the port, a released one the pull level.
   Assumes pin_oe_n low means the device drives. */
`timescale 1ns/1ns
module sppr_board_model (
  // Device side
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe_n,
  // Board side
  input  wire logic [15:0] pull_lvl,
  output logic      [15:0] pin_in
);
  // Released pins never keep the last driven value
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & pull_lvl);
endmodule

// [sppr_port_tb.sv]
/* Self-checking bench for sppr_port over APB.
   Top pin left unimplemented; board pulls released pins high. */
`timescale 1ns/1ns
module sppr_port_tb
  import sppr_pkg::*;
;
  localparam logic [15:0] VM = 16'h7fff;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, sck, sdi;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] pdrv, pout, pin, pin_in, pin_out, oe_n;
  logic [25:0] rp;
  int          bad_count, n_checks;
  sppr_port #(.VALID_MASK(VM)) u_sppr_port (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .peri_drive(pdrv), .peri_out(pout),
    .peri_in(pin), .pin_in, .pin_out, .pin_oe_n(oe_n), .remappable_pin_n(rp),
    .serial_clock_input(sck), .serial_data_input(sdi));
  sppr_board_model u_sppr_board_model (.pin_out, .pin_oe_n(oe_n), .pull_lvl(16'hffff),
    .pin_in);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // One APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge pclk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (3000) @(posedge pclk);
    bad_count++;
    end_of_test();
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; pdrv = 16'h0; pout = 16'h0; rp = 26'h0; bad_count = 0; n_checks = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_DIR, 32'h0);
    chk("dir", {16'h0, VM}, r);
    apb(1'b0, OFF_SEL, 32'h0);
    chk("sel", {16'h0, SEL_RST}, r);
    apb(1'b0, OFF_PIN, 32'h0);
    chk("pins", {16'h0, VM}, r);
    apb(1'b0, 12'h014, 32'h0);
    chk("err", 32'h1, {31'h0, e});
    chk("err data", 32'h0, r);
    $display("reset test done");
    apb(1'b1, OFF_PIN, 32'hffff80a5);
    apb(1'b0, OFF_LAT, 32'h0);
    chk("lat", 32'ha5, r);
    apb(1'b1, OFF_DIR, 32'h0);
    settle();
    chk("oe", 32'h8000, {16'h0, oe_n});
    chk("out", 32'ha5, {16'h0, pin_out});
    chk("loop", 32'h0, {16'h0, pin});
    apb(1'b0, OFF_PIN, 32'h0);
    chk("pins", 32'ha5, r);
    $display("latch test done");
    pdrv <= 16'h000f;
    pout <= 16'h000a;
    settle();
    chk("off", 32'ha5, {16'h0, pin_out});
    apb(1'b1, OFF_PERI_EN, 32'hffff);
    settle();
    chk("own", 32'haa, {16'h0, pin_out});
    pdrv <= 16'h0;
    settle();
    chk("idle", 32'ha5, {16'h0, pin_out});
    pdrv <= 16'h000f;
    apb(1'b1, OFF_DIR, 32'hffff);
    settle();
    chk("oe", 32'hfff0, {16'h0, oe_n});
    apb(1'b0, OFF_PIN, 32'h0);
    chk("pins", 32'h7ffa, r);
    $display("peripheral test done");
    rp <= 26'h2000008;
    apb(1'b1, OFF_SEL, 32'hf903);
    settle();
    apb(1'b0, OFF_SEL, 32'h0);
    chk("sel", 32'h1903, r);
    chk("sck", 32'h1, {31'h0, sck});
    chk("sdi", 32'h1, {31'h0, sdi});
    rp <= 26'h3ffffff;
    // Ground and reserved codes all read low
    for (int c = 26; c < 32; c++) begin
      apb(1'b1, OFF_SEL, {19'h0, c[4:0], 3'h0, c[4:0]});
      settle();
      chk("gnd", 32'h0, {30'h0, sck, sdi});
    end
    $display("remap test done");
    // Mid-run reset must bring every pin back to input
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_DIR, 32'h0);
    chk("dir", {16'h0, VM}, r);
    chk("oe", 32'hffff, {16'h0, oe_n});
    $display("second reset test done");
    end_of_test();
  end
endmodule
bind sppr_port sppr_port_sva #(.VALID_MASK(VALID_MASK)) u_sppr_port_sva (.pclk, .presetn,
  .psel, .penable, .prdata, .pready, .pslverr, .pin_oe_n, .remappable_pin_n,
  .serial_clock_input, .serial_data_input);
